// [rtl/lps_sequencer.sv]
// Primitive sequencer: register slave, link state machine, retry timing
// What this block does
// - Init command fetches block from init address
// - Init done posts confirmation; host clears valid
// - Start makes line send flags continuously
// - Connect sends SABM, retries, reports exhaustion
// - UA to SABM gives connect confirmation
// - Disconnect sends DM or DISC by parameter
// - Received SABM indicates; connect response sends UA
// - Host refuses connect with disconnect request
// - Ownership returned on ack, transparent on send
// - Disconnect success confirms, enters disconnected state
// - Reset sends SABM; UA gives reset confirmation
// - Failed reset reports disconnect with reason
// - Remote reset indicated; host responds or disconnects
// - FRMR reports error, stores information field
// - XID request sends buffer, confirms remote reply
// - Received XID/TEST indicated; host responds
// - XID disabled: XID/TEST silently refused
// - Stop halts line, sets stop, disables interrupts
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "lps_map.svh"
module lps_sequencer #(
  parameter int RETRY_W = 12,
  parameter int TICK_CYCLES = (`LPS_TICK_NS * `LPS_CLK_MHZ) / 1000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Initialization block fetch
  output logic initFetch,
  output logic [23:0] initAddr,
  input wire logic initDone,
  // Received frames from the framer
  input wire logic rxFrameValid,
  input wire logic [2:0] rxFrameKind,
  output logic rxReady,
  // Descriptor ownership
  input wire logic txFrameDone,
  input wire logic txFrameAcked,
  output logic txOwnClear,
  output logic rxFrmrStore,
  output logic xidRxStore,
  // Line
  output logic txDataPin
);
  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : gBadTick
      $error("lps_sequencer tick count out of range");
    end
    if (RETRY_W < 1 || RETRY_W > 12) begin : gBadRetry
      $error("lps_sequencer retry field is 12 bits at most");
    end
  endgenerate

  localparam logic [12:0] TICK_LAST = 13'(TICK_CYCLES - 1);

  lps_txq_if txq ();
  lps_pkg::lps_state_t state;

  logic [15:0] ctrl0;
  logic [15:0] iaddrHi;
  logic [15:0] iaddrLo;
  logic [15:0] busCfg;
  logic [15:0] retryCfg;
  logic primPav;
  logic [3:0] primCode;
  logic [3:0] primParam;
  logic pendValid;
  logic [3:0] pendCode;
  logic [3:0] pendParam;
  logic postStb;
  logic [3:0] postCode;
  logic [3:0] postParam;
  logic txPend;
  logic [7:0] txCtl;
  logic xidWait;
  logic [12:0] tickCnt;
  logic [RETRY_W-1:0] t1Cnt;
  logic t1Expired;
  logic t1Restart;
  logic [3:0] sentCount;
  logic running;
  logic wbHit;
  logic wbWr;
  logic cmdValid;
  logic [3:0] cmdCode;
  logic [3:0] cmdParam;
  logic rxTake;
  logic xid_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode helpers
  function automatic logic regMapped(input logic [7:0] adr);
    regMapped = (adr[7:5] == 3'h0) && (adr[4:2] <= `LPS_IDX_RETRY);
  endfunction : regMapped

  function automatic logic [15:0] mergeSel(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
    mergeSel = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : mergeSel

  function automatic logic isReg(input logic [7:0] adr, input logic [2:0] idx);
    isReg = regMapped(adr) && (adr[4:2] == idx);
  endfunction : isReg

  assign wbHit = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wbWr = wbHit && wb_we_i && wb_ack_o;
  assign cmdValid = wbWr && isReg(wb_adr_i, `LPS_IDX_PRIM) && (wb_sel_i[1:0] == 2'h3)
                    && wb_dat_i[`LPS_PRIM_REQ_BIT];
  assign cmdCode = wb_dat_i[`LPS_CODE_HI:`LPS_CODE_LO];
  assign cmdParam = wb_dat_i[`LPS_PARAM_HI:`LPS_PARAM_LO];
  assign running = (state != lps_pkg::LPS_STOPPED) && (state != lps_pkg::LPS_INITING);
  assign rxTake = rxFrameValid && rxReady;
  assign xid_enable = iaddrHi[`LPS_XID_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, unmapped addresses answer zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbHit && !wb_ack_o;
      wb_dat_o <= 32'h0;
      if (wbHit && !wb_ack_o && regMapped(wb_adr_i)) begin
        unique case (wb_adr_i[4:2])
          `LPS_IDX_CTRL0: wb_dat_o <= {16'h0, ctrl0};
          `LPS_IDX_PRIM: begin
            wb_dat_o[`LPS_CODE_HI:`LPS_CODE_LO] <= primCode;
            wb_dat_o[`LPS_PRIM_PAV_BIT] <= primPav;
            wb_dat_o[`LPS_PARAM_HI:`LPS_PARAM_LO] <= primParam;
          end
          `LPS_IDX_IADDR_HI: wb_dat_o <= {16'h0, iaddrHi};
          `LPS_IDX_IADDR_LO: wb_dat_o <= {16'h0, iaddrLo};
          `LPS_IDX_BUSCFG: wb_dat_o <= {16'h0, busCfg};
          default: wb_dat_o <= {16'h0, retryCfg};
        endcase
      end
    end
  end

  // Host-owned setup registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      iaddrHi <= 16'h0;
      iaddrLo <= 16'h0;
      busCfg <= 16'h0;
      retryCfg <= `LPS_RETRY_RESET;
    end else if (wbWr) begin
      if (isReg(wb_adr_i, `LPS_IDX_IADDR_HI)) iaddrHi <= mergeSel(iaddrHi, wb_dat_i, wb_sel_i);
      if (isReg(wb_adr_i, `LPS_IDX_IADDR_LO)) iaddrLo <= mergeSel(iaddrLo, wb_dat_i, wb_sel_i);
      if (isReg(wb_adr_i, `LPS_IDX_BUSCFG)) busCfg <= mergeSel(busCfg, wb_dat_i, wb_sel_i);
      if (isReg(wb_adr_i, `LPS_IDX_RETRY)) retryCfg <= mergeSel(retryCfg, wb_dat_i, wb_sel_i);
    end
  end

  // Control word; stop status is hardware owned and wins over software
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl0 <= `LPS_CTRL0_RESET;
    end else begin
      if (wbWr && isReg(wb_adr_i, `LPS_IDX_CTRL0)) begin
        ctrl0[`LPS_CTRL0_INTEN_BIT] <= wb_dat_i[`LPS_CTRL0_INTEN_BIT];
        ctrl0[`LPS_CTRL0_TRANSP_BIT] <= wb_dat_i[`LPS_CTRL0_TRANSP_BIT];
      end
      if (cmdValid && cmdCode == `LPS_UP_STOP) begin
        ctrl0[`LPS_CTRL0_STOP_BIT] <= 1'b1;
        ctrl0[`LPS_CTRL0_INTEN_BIT] <= 1'b0;
      end else if (cmdValid && cmdCode == `LPS_UP_START && state == lps_pkg::LPS_STOPPED) begin
        ctrl0[`LPS_CTRL0_STOP_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Provider slot: one event may wait behind a posted primitive
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      primPav <= 1'b0;
      primCode <= 4'h0;
      primParam <= 4'h0;
      pendValid <= 1'b0;
      pendCode <= 4'h0;
      pendParam <= 4'h0;
    end else begin
      if (wbWr && isReg(wb_adr_i, `LPS_IDX_PRIM) && !wb_dat_i[`LPS_PRIM_REQ_BIT]
          && wb_dat_i[`LPS_PRIM_PAV_BIT]) begin
        primPav <= 1'b0;
      end
      if (postStb) begin
        pendValid <= 1'b1;
        pendCode <= postCode;
        pendParam <= postParam;
      end else if (pendValid && !primPav) begin
        // Posting overrides a clear in the same cycle
        primPav <= 1'b1;
        primCode <= pendCode;
        primParam <= pendParam;
        pendValid <= 1'b0;
      end
    end
  end

  // Frames are only accepted while an indication can be queued
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rxReady <= 1'b0;
    end else begin
      rxReady <= running && !pendValid && !postStb && !rxTake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry timer in ticks of a microsecond
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tickCnt <= 13'h0;
      t1Cnt <= '0;
      t1Expired <= 1'b0;
    end else begin
      t1Expired <= 1'b0;
      if (t1Restart) begin
        tickCnt <= 13'h0;
        t1Cnt <= retryCfg[RETRY_W-1:0];
      end else if ((state == lps_pkg::LPS_CONN_SENT || state == lps_pkg::LPS_RESET_SENT
                   || state == lps_pkg::LPS_DISC_SENT) && !rxTake && !cmdValid) begin
        if (tickCnt == TICK_LAST) begin
          tickCnt <= 13'h0;
          if (t1Cnt <= RETRY_W'(1)) begin
            t1Expired <= 1'b1;
            t1Cnt <= retryCfg[RETRY_W-1:0];
          end else begin
            t1Cnt <= t1Cnt - RETRY_W'(1);
          end
        end else begin
          tickCnt <= tickCnt + 13'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor ownership return
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      txOwnClear <= 1'b0;
    end else begin
      txOwnClear <= running && (ctrl0[`LPS_CTRL0_TRANSP_BIT] ? txFrameDone : txFrameAcked);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= lps_pkg::LPS_STOPPED;
      postStb <= 1'b0;
      postCode <= 4'h0;
      postParam <= 4'h0;
      txPend <= 1'b0;
      txCtl <= `LPS_CTL_FLAG;
      xidWait <= 1'b0;
      sentCount <= 4'h0;
      t1Restart <= 1'b0;
      initFetch <= 1'b0;
      initAddr <= 24'h0;
      rxFrmrStore <= 1'b0;
      xidRxStore <= 1'b0;
    end else begin
      postStb <= 1'b0;
      t1Restart <= 1'b0;
      initFetch <= 1'b0;
      rxFrmrStore <= 1'b0;
      xidRxStore <= 1'b0;
      if (txq.taken) txPend <= 1'b0;
      if (cmdValid && cmdCode == `LPS_UP_STOP) begin
        state <= lps_pkg::LPS_STOPPED;
        txPend <= 1'b0;
        xidWait <= 1'b0;
      end else if (cmdValid && cmdCode == `LPS_UP_INIT && !running) begin
        initAddr <= {iaddrHi[7:0], iaddrLo};
        initFetch <= 1'b1;
        state <= lps_pkg::LPS_INITING;
      end else if (state == lps_pkg::LPS_INITING) begin
        if (initDone) begin
          postStb <= 1'b1;
          postCode <= `LPS_PP_INIT_CONF;
          postParam <= `LPS_PARM_INIT;
          state <= lps_pkg::LPS_STOPPED;
        end
      end else if (cmdValid && cmdCode == `LPS_UP_START && state == lps_pkg::LPS_STOPPED) begin
        state <= lps_pkg::LPS_DISC;
      end else if (cmdValid && running) begin
        unique case (cmdCode)
          `LPS_UP_CONN_REQ: begin
            txPend <= 1'b1;
            txCtl <= `LPS_CTL_SABM | `LPS_CTL_PF;
            sentCount <= 4'h1;
            t1Restart <= 1'b1;
            state <= lps_pkg::LPS_CONN_SENT;
          end
          `LPS_UP_CONN_RSP: begin
            if (state == lps_pkg::LPS_CONN_IND) begin
              txPend <= 1'b1;
              txCtl <= `LPS_CTL_UA;
              state <= lps_pkg::LPS_INFO;
            end
          end
          `LPS_UP_RST_REQ, `LPS_UP_RST_RSP: begin
            txPend <= 1'b1;
            if (state == lps_pkg::LPS_RST_IND && cmdCode == `LPS_UP_RST_RSP) begin
              txCtl <= `LPS_CTL_UA;
              state <= lps_pkg::LPS_INFO;
            end else begin
              txCtl <= `LPS_CTL_SABM | `LPS_CTL_PF;
              sentCount <= 4'h1;
              t1Restart <= 1'b1;
              state <= lps_pkg::LPS_RESET_SENT;
            end
          end
          `LPS_UP_XID_REQ: begin
            if (xid_enable) begin
              txPend <= 1'b1;
              txCtl <= `LPS_CTL_XID | `LPS_CTL_PF;
              xidWait <= 1'b1;
            end
          end
          `LPS_UP_XID_RSP, `LPS_UP_TEST_RSP: begin
            txPend <= 1'b1;
            txCtl <= (cmdCode == `LPS_UP_XID_RSP) ? `LPS_CTL_XID : `LPS_CTL_TEST;
          end
          `LPS_UP_DISC_REQ: begin
            txPend <= 1'b1;
            xidWait <= 1'b0;
            if (cmdParam == 4'h1) begin
              txCtl <= `LPS_CTL_DISC;
              sentCount <= 4'h1;
              t1Restart <= 1'b1;
              state <= lps_pkg::LPS_DISC_SENT;
            end else begin
              txCtl <= `LPS_CTL_DM;
              state <= lps_pkg::LPS_DISC;
            end
          end
          default: begin
          end
        endcase
      end else if (t1Expired && !txPend && !rxTake) begin
        if (sentCount >= retryCfg[15:12]) begin
          postStb <= 1'b1;
          postCode <= `LPS_PP_DISC_IND;
          postParam <= `LPS_PARM_RETRY;
          state <= lps_pkg::LPS_DISC;
        end else begin
          txPend <= 1'b1;
          txCtl <= (state == lps_pkg::LPS_DISC_SENT) ? `LPS_CTL_DISC : (`LPS_CTL_SABM | `LPS_CTL_PF);
          sentCount <= sentCount + 4'h1;
        end
      end else if (rxTake) begin
        unique case (lps_pkg::lps_rxkind_t'(rxFrameKind))
          lps_pkg::LPS_RX_SABM: begin
            postStb <= 1'b1;
            postParam <= `LPS_PARM_NONE;
            if (state == lps_pkg::LPS_INFO) begin
              postCode <= `LPS_PP_RST_IND;
              state <= lps_pkg::LPS_RST_IND;
            end else begin
              postCode <= `LPS_PP_CONN_IND;
              state <= lps_pkg::LPS_CONN_IND;
            end
          end
          lps_pkg::LPS_RX_UA: begin
            postParam <= `LPS_PARM_NONE;
            if (state == lps_pkg::LPS_CONN_SENT) begin
              postStb <= 1'b1;
              postCode <= `LPS_PP_CONN_CONF;
              state <= lps_pkg::LPS_INFO;
            end else if (state == lps_pkg::LPS_RESET_SENT) begin
              postStb <= 1'b1;
              postCode <= `LPS_PP_RST_CONF;
              state <= lps_pkg::LPS_INFO;
            end else if (state == lps_pkg::LPS_DISC_SENT) begin
              postStb <= 1'b1;
              postCode <= `LPS_PP_DISC_CONF;
              state <= lps_pkg::LPS_DISC;
            end
          end
          lps_pkg::LPS_RX_DM, lps_pkg::LPS_RX_DISC: begin
            postParam <= `LPS_PARM_NONE;
            if (rxFrameKind == 3'(lps_pkg::LPS_RX_DISC)) begin
              txPend <= 1'b1;
              txCtl <= `LPS_CTL_UA;
            end
            if (state == lps_pkg::LPS_DISC_SENT) begin
              postStb <= 1'b1;
              postCode <= `LPS_PP_DISC_CONF;
            end else if (state != lps_pkg::LPS_DISC) begin
              postStb <= 1'b1;
              postCode <= `LPS_PP_DISC_IND;
            end
            state <= lps_pkg::LPS_DISC;
          end
          lps_pkg::LPS_RX_FRMR: begin
            postStb <= 1'b1;
            postCode <= `LPS_PP_ERR_IND;
            postParam <= `LPS_PARM_FRMR;
            rxFrmrStore <= 1'b1;
          end
          lps_pkg::LPS_RX_XID, lps_pkg::LPS_RX_TEST: begin
            if (xid_enable) begin
              postStb <= 1'b1;
              postParam <= `LPS_PARM_NONE;
              xidRxStore <= 1'b1;
              if (rxFrameKind == 3'(lps_pkg::LPS_RX_TEST)) begin
                postCode <= `LPS_PP_TEST_IND;
              end else if (xidWait) begin
                postCode <= `LPS_PP_XID_CONF;
                xidWait <= 1'b0;
              end else begin
                postCode <= `LPS_PP_XID_IND;
              end
            end
            // Disabled: dropped without any indication
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign txq.run = running;
  assign txq.req = txPend;
  assign txq.ctl = txCtl;

  lps_frame_tx #(
    .OCTET_W(8)
  ) uFrameTx (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .txq(txq),
    .txDataPin(txDataPin)
  );
endmodule : lps_sequencer

// [rtl/lps_map.svh]
// Register indexes, field positions, reset values, codes and timing for the primitive sequencer
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
`define LPS_IDX_CTRL0 3'h0
`define LPS_IDX_PRIM 3'h1
`define LPS_IDX_IADDR_HI 3'h2
`define LPS_IDX_IADDR_LO 3'h3
`define LPS_IDX_BUSCFG 3'h4
`define LPS_IDX_RETRY 3'h5
`define LPS_PRIM_REQ_BIT 14
`define LPS_PRIM_PAV_BIT 6
`define LPS_CODE_HI 11
`define LPS_CODE_LO 8
`define LPS_PARAM_HI 3
`define LPS_PARAM_LO 0
`define LPS_CTRL0_STOP_BIT 2
`define LPS_CTRL0_TRANSP_BIT 3
`define LPS_CTRL0_INTEN_BIT 6
`define LPS_XID_ENABLE_BIT 15
`define LPS_CTRL0_RESET 16'h0004
`define LPS_RETRY_RESET 16'h3064
`define LPS_UP_STOP 4'h1
`define LPS_UP_INIT 4'h2
`define LPS_UP_START 4'h3
`define LPS_UP_CONN_REQ 4'h6
`define LPS_UP_CONN_RSP 4'h7
`define LPS_UP_RST_REQ 4'h8
`define LPS_UP_RST_RSP 4'h9
`define LPS_UP_XID_REQ 4'ha
`define LPS_UP_XID_RSP 4'hb
`define LPS_UP_TEST_RSP 4'hd
`define LPS_UP_DISC_REQ 4'he
`define LPS_PP_INIT_CONF 4'h2
`define LPS_PP_ERR_IND 4'h4
`define LPS_PP_CONN_IND 4'h6
`define LPS_PP_CONN_CONF 4'h7
`define LPS_PP_RST_IND 4'h8
`define LPS_PP_RST_CONF 4'h9
`define LPS_PP_XID_IND 4'ha
`define LPS_PP_XID_CONF 4'hb
`define LPS_PP_TEST_IND 4'hc
`define LPS_PP_DISC_IND 4'he
`define LPS_PP_DISC_CONF 4'hf
`define LPS_PARM_NONE 4'h0
`define LPS_PARM_RETRY 4'h1
`define LPS_PARM_FRMR 4'h2
`define LPS_PARM_INIT 4'h2
`define LPS_CTL_FLAG 8'h7e
`define LPS_CTL_SABM 8'h2f
`define LPS_CTL_PF 8'h10
`define LPS_CTL_UA 8'h63
`define LPS_CTL_DM 8'h0f
`define LPS_CTL_DISC 8'h43
`define LPS_CTL_XID 8'haf
`define LPS_CTL_TEST 8'he3
`define LPS_TICK_NS 1000
`define LPS_CLK_MHZ 125
`endif

// [rtl/lps_pkg.sv]
// Types shared by the primitive sequencer modules
package lps_pkg;
  typedef enum logic [3:0] {
    LPS_STOPPED = 4'h0,
    LPS_INITING = 4'h1,
    LPS_DISC = 4'h3,
    LPS_CONN_SENT = 4'h2,
    LPS_INFO = 4'h6,
    LPS_RESET_SENT = 4'h7,
    LPS_DISC_SENT = 4'h5,
    LPS_CONN_IND = 4'h4,
    LPS_RST_IND = 4'hc
  } lps_state_t;
  typedef enum logic [2:0] {
    LPS_RX_SABM = 3'h0,
    LPS_RX_UA = 3'h1,
    LPS_RX_DM = 3'h2,
    LPS_RX_DISC = 3'h3,
    LPS_RX_FRMR = 3'h4,
    LPS_RX_XID = 3'h5,
    LPS_RX_TEST = 3'h6,
    LPS_RX_OTHER = 3'h7
  } lps_rxkind_t;
endpackage : lps_pkg

// [rtl/lps_txq_if.sv]
// Frame request channel from the sequencer to the line serializer
`timescale 1ns/10ps
interface lps_txq_if;
  logic run;
  logic req;
  logic [7:0] ctl;
  logic taken;
  modport seq (output run, output req, output ctl, input taken);
  modport ser (input run, input req, input ctl, output taken);
endinterface : lps_txq_if

// [rtl/lps_frame_tx.sv]
// Line serializer: idle flags, one control octet per frame, line held high when stopped
`timescale 1ns/10ps
`include "lps_map.svh"
module lps_frame_tx #(
  parameter int OCTET_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Frame requests
  lps_txq_if.ser txq,
  // Line
  output logic txDataPin
);
  generate
    if (OCTET_W != 8) begin : gBadWidth
      $error("lps_frame_tx serves octets only");
    end
  endgenerate

  logic [OCTET_W-1:0] shifter;
  logic [2:0] bitCnt;

  ////////////////////////////////////////////////////////////////////////////
  // No zero insertion here: octets are sent as given, flags between frames
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      shifter <= `LPS_CTL_FLAG;
      bitCnt <= 3'h0;
      txDataPin <= 1'b1;
      txq.taken <= 1'b0;
    end else if (!txq.run) begin
      // Stop aborts any octet on the line at once
      shifter <= `LPS_CTL_FLAG;
      bitCnt <= 3'h0;
      txDataPin <= 1'b1;
      txq.taken <= 1'b0;
    end else begin
      txDataPin <= shifter[0];
      txq.taken <= 1'b0;
      if (bitCnt == 3'h7) begin
        bitCnt <= 3'h0;
        if (txq.req && !txq.taken) begin
          shifter <= txq.ctl;
          txq.taken <= 1'b1;
        end else begin
          shifter <= `LPS_CTL_FLAG;
        end
      end else begin
        bitCnt <= bitCnt + 3'h1;
        shifter <= {1'b0, shifter[OCTET_W-1:1]};
      end
    end
  end
endmodule : lps_frame_tx

// [testbench/lps_seq_monitor.sv]
// Port-level checker for the primitive sequencer
`timescale 1ns/10ps
module lps_seq_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link side
  input wire logic initFetch,
  input wire logic [23:0] initAddr,
  input wire logic rxFrameValid,
  input wire logic rxReady,
  input wire logic txFrameDone,
  input wire logic txFrameAcked,
  input wire logic txOwnClear,
  input wire logic rxFrmrStore,
  input wire logic txDataPin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic wrAck;
  assign wrAck = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_sel_i[1:0] == 2'h3);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_fetch; wrAck && wb_adr_i == 8'h04 && wb_dat_i[15:0] == 16'h4200 |-> ##[1:2] initFetch; endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch after init");
  property p_addr; $changed(initAddr) |-> initFetch; endproperty
  a_addr: assert property (p_addr) else $error("address moved without fetch");
  property p_stop; wrAck && wb_adr_i == 8'h04 && wb_dat_i[15:0] == 16'h4100 |-> ##2 txDataPin [*8]; endproperty
  a_stop: assert property (p_stop) else $error("line not high after stop");
  property p_own; txOwnClear |-> $past(txFrameAcked) || $past(txFrameDone); endproperty
  a_own: assert property (p_own) else $error("ownership returned early");
  property p_take; rxFrameValid && rxReady |=> !rxReady; endproperty
  a_take: assert property (p_take) else $error("second frame taken");
  c_fetch: cover property (initFetch);
  c_frmr: cover property (rxFrmrStore);
  c_own: cover property (txOwnClear);
endmodule : lps_seq_monitor
bind lps_sequencer lps_seq_monitor u_mon (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .initFetch, .initAddr, .rxFrameValid, .rxReady,
  .txFrameDone, .txFrameAcked, .txOwnClear, .rxFrmrStore, .txDataPin);

// [testbench/lps_far_end.sv]
// Far-side model: block fetch, received frames, transmit completions
`timescale 1ns/10ps
module lps_far_end (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Device side
  input wire logic initFetch,
  input wire logic rxReady,
  output logic initDone,
  output logic rxFrameValid,
  output logic [2:0] rxFrameKind,
  output logic txFrameDone,
  output logic txFrameAcked,
  // Bench commands
  input wire logic sendGo,
  input wire logic [2:0] sendKind,
  input wire logic txPulse
);
  logic [3:0] dly;
  logic [2:0] tdly;
  // Fetch takes a few cycles
  always_ff @(posedge ref_clk) begin
    dly <= rst_b ? {dly[2:0], initFetch} : 4'h0;
    initDone <= rst_b & dly[3];
  end
  always_ff @(posedge ref_clk) begin
    tdly <= rst_b ? {tdly[1:0], txPulse} : 3'h0;
    txFrameDone <= rst_b & txPulse;
    txFrameAcked <= rst_b & tdly[2];
  end
  // Kind lines carry junk once a frame is taken
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rxFrameValid <= 1'b0;
      rxFrameKind <= 3'h0;
    end else if (sendGo) begin
      rxFrameValid <= 1'b1;
      rxFrameKind <= sendKind;
    end else if (rxFrameValid && rxReady) begin
      rxFrameValid <= 1'b0;
      rxFrameKind <= ~rxFrameKind;
    end
  end
endmodule : lps_far_end

// [testbench/link_primitive_sequencer_tb.sv]
// Self-checking bench for the primitive sequencer
`timescale 1ns/10ps
module link_primitive_sequencer_tb;
  logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, initFetch, initDone, rxFrameValid, rxReady;
  logic txFrameDone, txFrameAcked, txOwnClear, rxFrmrStore, xidRxStore, txDataPin, sendGo, txPulse;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [23:0] initAddr;
  logic [2:0] rxFrameKind, sendKind;
  logic [15:0] q;
  int err_total, checked, fs, xs, oc, n;
  lps_sequencer #(.TICK_CYCLES(1)) u_dut (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .initFetch, .initAddr, .initDone, .rxFrameValid,
    .rxFrameKind, .rxReady, .txFrameDone, .txFrameAcked, .txOwnClear, .rxFrmrStore, .xidRxStore, .txDataPin);
  lps_far_end u_far (.ref_clk, .rst_b, .initFetch, .rxReady, .initDone, .rxFrameValid, .rxFrameKind,
    .txFrameDone, .txFrameAcked, .sendGo, .sendKind, .txPulse);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    fs += (rxFrmrStore === 1'b1);
    xs += (xidRxStore === 1'b1);
    oc += (txOwnClear === 1'b1);
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 16'h0000, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o[15:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k >= 50) begin
      err_total++;
      close_out();
    end
  endtask : wb
  // Command, frame, poll, compare, clear
  task automatic post(input logic [15:0] cmd, input logic snd, input logic [2:0] k, input logic [15:0] exp);
    if (cmd !== 16'h0000) wb(1'b1, 8'h04, cmd);
    if (snd) begin
      @(posedge ref_clk);
      {sendGo, sendKind} <= {1'b1, k};
      @(posedge ref_clk);
      sendGo <= 1'b0;
    end
    n = 0;
    do begin
      wb(1'b0, 8'h04, 16'h0000);
      n++;
    end while (q[6] !== 1'b1 && n < 300);
    chk(q, exp);
    if (n >= 300) close_out();
    wb(1'b1, 8'h04, 16'h0040);
  endtask : post
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, 8'h00, 16'h0000);
    chk(q, 16'h0004);
    wb(1'b0, 8'h14, 16'h0000);
    chk(q, 16'h3064);
    wb(1'b1, 8'h1c, 16'hffff);
    wb(1'b0, 8'h1c, 16'h0000);
    chk(q, 16'h0000);
    wb(1'b1, 8'h10, 16'h00a5);
    wb(1'b0, 8'h10, 16'h0000);
    chk(q, 16'h00a5);
  endtask : t_regs
  task automatic t_init();
    wb(1'b1, 8'h08, 16'h8012);
    wb(1'b1, 8'h0c, 16'h3456);
    post(16'h4200, 1'b0, 3'h0, 16'h0242);
    chk(initAddr[15:0], 16'h3456);
    chk({8'h00, initAddr[23:16]}, 16'h0012);
    wb(1'b0, 8'h04, 16'h0000);
    chk(q & 16'h0040, 16'h0000);
  endtask : t_init
  task automatic t_start();
    wb(1'b1, 8'h04, 16'h4300);
    n = 0;
    repeat (24) @(posedge ref_clk) n += (txDataPin === 1'b0);
    chk(16'(n != 0), 16'h0001);
    wb(1'b1, 8'h00, 16'h0040);
    wb(1'b0, 8'h00, 16'h0000);
    chk(q & 16'h0040, 16'h0040);
  endtask : t_start
  task automatic t_link();
    wb(1'b1, 8'h14, 16'h2002);
    post(16'h4600, 1'b0, 3'h0, 16'h0e41);
    wb(1'b1, 8'h14, 16'hf0ff);
    post(16'h4600, 1'b1, 3'h1, 16'h0740);
    post(16'h0000, 1'b1, 3'h4, 16'h0442);
    chk(16'(fs), 16'h0001);
    post(16'h4800, 1'b1, 3'h1, 16'h0940);
    post(16'h0000, 1'b1, 3'h5, 16'h0a40);
    chk(16'(xs), 16'h0001);
    post(16'h4e01, 1'b1, 3'h1, 16'h0f40);
  endtask : t_link
  task automatic t_stop();
    @(posedge ref_clk) txPulse <= 1'b1;
    @(posedge ref_clk) txPulse <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(16'(oc), 16'h0001);
    wb(1'b1, 8'h04, 16'h4100);
    repeat (2) @(posedge ref_clk);
    n = 0;
    repeat (16) @(posedge ref_clk) n += (txDataPin === 1'b1);
    chk(16'(n), 16'h0010);
    wb(1'b0, 8'h00, 16'h0000);
    chk(q & 16'h0044, 16'h0004);
    wb(1'b1, 8'h04, 16'h4300);
    wb(1'b0, 8'h00, 16'h0000);
    chk(q & 16'h0004, 16'h0000);
  endtask : t_stop
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, sendGo, txPulse} = 6'h0;
    {wb_adr_i, wb_dat_i, sendKind} = '0;
    wb_sel_i = 4'h3;
    {err_total, checked, fs, xs, oc} = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_init();
    t_start();
    t_link();
    t_stop();
    close_out();
  end
endmodule : link_primitive_sequencer_tb
